//--- vrs_pkg.sv
// Purpose: shared constants, types and helpers of the vid reference sequencer
// Assumes: reference levels count in 12.5 mV steps, level 0 is near zero
// Notes: vid codes map to levels by subtraction from the full-scale level

package vrs_pkg;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int SLEW_UV_PER_US = 3250;
    localparam int LSB_UV = 12500;
    localparam int STEP_NS = (LSB_UV * 1000) / SLEW_UV_PER_US;
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    localparam int SS_STEP_NS = 2000;
    localparam int SS_STEP_CYC = SS_STEP_NS / CLK_NS;
    localparam int TICK_W = 12;

    // --------------------------------------------------------------------
    // codes and reset values
    // --------------------------------------------------------------------
    localparam logic [6:0] VID_OFF_FIRST = 7'h7c;
    localparam logic [6:0] LEVEL_FULL = 7'h7c;
    localparam logic [6:0] LEVEL_ZERO = 7'h00;
    // index is {strap clock, strap data}
    localparam logic [3:0][6:0] BOOT_VID = {7'h3c, 7'h34, 7'h2c, 7'h24};
    localparam logic [3:0][6:0] FIX_VID = {7'h3c, 7'h2c, 7'h1c, 7'h0c};
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam int MAX_PHASES = 4;

    // --------------------------------------------------------------------
    // types
    // --------------------------------------------------------------------
    typedef struct packed {
        logic core_sel;
        logic nb_sel;
        logic ps_keep;
        logic [6:0] vid;
    } vrs_cmd_s;

    typedef struct packed {
        logic [6:0] core;
        logic [6:0] nb;
    } vrs_lvl_s;

    typedef enum logic [1:0] {ST_IDLE, ST_SOFT, ST_RUN, ST_DOWN} vrs_state_e;

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic [6:0] vid_to_level(input logic [6:0] code);
        return (code >= VID_OFF_FIRST) ? LEVEL_ZERO : LEVEL_FULL - code;
    endfunction : vid_to_level

    function automatic logic [6:0] step_toward(input logic [6:0] cur,
                                               input logic [6:0] tgt);
        if (cur < tgt) begin
            return cur + 7'h01;
        end else if (cur > tgt) begin
            return cur - 7'h01;
        end
        return cur;
    endfunction : step_toward

    function automatic vrs_lvl_s apply_cmd(input vrs_lvl_s cur,
                                           input vrs_cmd_s c);
        vrs_lvl_s r;
        r = cur;
        if (c.core_sel) begin
            r.core = vid_to_level(c.vid);
        end
        if (c.nb_sel) begin
            r.nb = vid_to_level(c.vid);
        end
        return r;
    endfunction : apply_cmd

endpackage : vrs_pkg

//--- vrs_sequencer.sv
// Purpose: vid selection, soft-start, serial vid and phase shedding control
// Assumes: pwm_rise comes from modulator logic clocked by mclk
// Notes: link receiver runs on link_clk, commands cross by a toggle
//
// Summary of operation
// - decode straps only after power-on reset
// - boot straps select 1.1, 1.0, 0.9, 0.8 V
// - latch boot target on enable rise
// - soft-start raises reference in single stair steps
// - power good rises when soft-start ends regulated
// - enable fall drops power good, ramps down
// - fixed select picks 1.4, 1.2, 1.0, 0.8 V
// - fixed mode follows strap changes while host power ok is low
// - commands accepted only after host power ok
// - command steps each addressed plane to target
// - core commanded off keeps power good high
// - host power ok fall returns to held target
// - host power ok rise waits for commands
// - lost regulation ramps both planes to zero
// - vid codes step 12.5 mV, top codes off
// - command bit seven carries power save request
// - shed phase four, three, then two
// - shed phase tristates at its next pwm rise
// - restore from phase two at pwm rise
// - core level change in save: exit, step, reenter
// - run slew is 3.25 mV per us

`timescale 1ns/1ps

module vrs_sequencer #(
    parameter int NUM_PHASES = vrs_pkg::MAX_PHASES,
    parameter int SLEW_STEP_CYC = vrs_pkg::STEP_CYC,
    parameter int SOFT_STEP_CYC = vrs_pkg::SS_STEP_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // straps and control pins
    input wire logic por_ok,
    input wire logic enable,
    input wire logic fixed_voltage_select,
    input wire logic host_power_ok,
    input wire logic strap_clock_level,
    input wire logic serial_vid_data_line,
    // serial vid link
    input wire logic link_clk,
    input wire logic frame_active,
    // regulation status
    input wire logic core_in_reg,
    input wire logic nb_in_reg,
    // modulator
    input wire logic [3:0] pwm_rise,
    // outputs
    output vrs_pkg::vrs_lvl_s ref_level,
    output logic plane_power_good,
    output logic [3:0] phase_tristate,
    output logic power_save_active,
    output logic fixed_voltage_mode
);
    import vrs_pkg::*;

    if (NUM_PHASES < 1 || NUM_PHASES > MAX_PHASES) begin : g_chk_ph
        $error("NUM_PHASES out of range");
    end
    if (SLEW_STEP_CYC < 1 || SLEW_STEP_CYC >= (1 << TICK_W) ||
        SOFT_STEP_CYC < 1 || SOFT_STEP_CYC >= (1 << TICK_W)) begin : g_chk_t
        $error("step interval out of range");
    end

    localparam logic [3:1] CFG_MASK = 3'((1 << (NUM_PHASES - 1)) - 1);
    localparam logic [TICK_W-1:0] RUN_LAST = TICK_W'(SLEW_STEP_CYC - 1);
    localparam logic [TICK_W-1:0] SOFT_LAST = TICK_W'(SOFT_STEP_CYC - 1);

    // --------------------------------------------------------------------
    // link side receiver
    // --------------------------------------------------------------------
    // a frame cut short clears its bit count at the next link_clk rise seen with frame_active low
    logic [8:0] shift_r;
    logic [3:0] bit_cnt_r;
    vrs_cmd_s cap_r;
    logic tog_r;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 9'h000;
            bit_cnt_r <= 4'h0;
            cap_r <= '0;
            tog_r <= 1'b0;
        end else if (!frame_active) begin
            bit_cnt_r <= 4'h0;
        end else if (bit_cnt_r == FRAME_LAST) begin
            cap_r <= {shift_r, serial_vid_data_line};
            tog_r <= ~tog_r;
            bit_cnt_r <= 4'h0;
        end else begin
            shift_r <= {shift_r[7:0], serial_vid_data_line};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // --------------------------------------------------------------------
    // synchronisers
    // --------------------------------------------------------------------
    logic [8:0] meta_r;
    logic [8:0] sync_r;
    logic tog_seen_r;
    logic en_d_r;
    logic pok_d_r;
    wire [8:0] raw_in = {por_ok, enable, fixed_voltage_select, host_power_ok,
                         strap_clock_level, serial_vid_data_line,
                         core_in_reg, nb_in_reg, tog_r};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 9'h000;
            sync_r <= 9'h000;
            tog_seen_r <= 1'b0;
            en_d_r <= 1'b0;
            pok_d_r <= 1'b0;
        end else begin
            meta_r <= raw_in;
            sync_r <= meta_r;
            tog_seen_r <= sync_r[0];
            en_d_r <= sync_r[7];
            pok_d_r <= sync_r[5];
        end
    end

    wire por_s = sync_r[8];
    wire en_s = sync_r[7];
    wire fixed_s = sync_r[6];
    wire pok_s = sync_r[5];
    wire [1:0] strap_sel = sync_r[4:3];
    wire core_good_s = sync_r[2];
    wire nb_good_s = sync_r[1];
    wire en_rise = en_s & ~en_d_r;
    wire pok_fall = ~pok_s & pok_d_r;
    // cap_r is stable for a whole frame after the toggle moves
    wire cmd_new = sync_r[0] ^ tog_seen_r;
    wire vrs_cmd_s cmd_in = cap_r;

    // --------------------------------------------------------------------
    // decode
    // --------------------------------------------------------------------
    logic [1:0] state_r;
    vrs_state_e state;
    vrs_state_e state_nxt;
    logic [6:0] hold_r;
    logic [6:0] hold_nxt;
    vrs_lvl_s tgt_r;
    vrs_lvl_s tgt_nxt;
    vrs_lvl_s ref_r;
    logic [TICK_W-1:0] tick_r;
    logic pg_r;
    logic pg_nxt;
    logic ps_req_r;
    logic ps_req_nxt;
    logic defer_r;
    logic defer_nxt;
    vrs_cmd_s defer_cmd_r;
    vrs_cmd_s defer_cmd_nxt;
    logic [3:1] active_r;

    assign state = vrs_state_e'(state_r);
    wire [6:0] boot_vid = fixed_s ? FIX_VID[strap_sel]
                                  : BOOT_VID[strap_sel];
    wire [6:0] boot_lvl = vid_to_level(boot_vid);
    wire vrs_lvl_s boot_pair = '{core: boot_lvl, nb: boot_lvl};
    wire vrs_lvl_s hold_pair = '{core: vid_to_level(hold_r),
                                 nb: vid_to_level(hold_r)};
    wire vrs_lvl_s cmd_tgt = apply_cmd(tgt_r, cmd_in);
    wire vrs_lvl_s defer_tgt = apply_cmd(tgt_r, defer_cmd_r);
    wire at_target = (ref_r == tgt_r);
    // a core plane commanded off does not count against regulation
    wire regulation_ok = (core_good_s | (tgt_r.core == LEVEL_ZERO))
                         & nb_good_s;
    // a power ok rise alone changes nothing; the next command does
    wire cmd_take = cmd_new & pok_s & (state == ST_RUN);
    wire in_save = (active_r != CFG_MASK);
    wire core_moves = cmd_in.core_sel &
                      (vid_to_level(cmd_in.vid) != tgt_r.core);
    wire fixed_track = fixed_s & (boot_vid != hold_r);

    // --------------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------------
    always_comb begin
        state_nxt = state;
        tgt_nxt = tgt_r;
        hold_nxt = hold_r;
        pg_nxt = pg_r;
        ps_req_nxt = ps_req_r;
        defer_nxt = defer_r;
        defer_cmd_nxt = defer_cmd_r;
        unique case (state)
            ST_IDLE: begin
                pg_nxt = 1'b0;
                if (por_s && en_rise) begin
                    hold_nxt = boot_vid;
                    tgt_nxt = boot_pair;
                    state_nxt = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (!en_s) begin
                    tgt_nxt = '0;
                    state_nxt = ST_DOWN;
                end else if (fixed_track) begin
                    hold_nxt = boot_vid;
                    tgt_nxt = boot_pair;
                end else if (at_target && regulation_ok) begin
                    pg_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!en_s || !regulation_ok) begin
                    pg_nxt = 1'b0;
                    tgt_nxt = '0;
                    ps_req_nxt = 1'b0;
                    defer_nxt = 1'b0;
                    state_nxt = ST_DOWN;
                end else if (pok_fall) begin
                    tgt_nxt = hold_pair;
                    ps_req_nxt = 1'b0;
                    defer_nxt = 1'b0;
                end else if (!pok_s && fixed_track) begin
                    hold_nxt = boot_vid;
                    tgt_nxt = boot_pair;
                end else if (cmd_take) begin
                    ps_req_nxt = ~cmd_in.ps_keep;
                    if (in_save && !cmd_in.ps_keep && core_moves) begin
                        defer_nxt = 1'b1;
                        defer_cmd_nxt = cmd_in;
                    end else begin
                        tgt_nxt = cmd_tgt;
                        defer_nxt = 1'b0;
                    end
                end else if (defer_r && !in_save) begin
                    tgt_nxt = defer_tgt;
                    defer_nxt = 1'b0;
                end
            end
            ST_DOWN: begin
                pg_nxt = 1'b0;
                tgt_nxt = '0;
                if (ref_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // --------------------------------------------------------------------
    // reference stepping
    // --------------------------------------------------------------------
    // soft-start and ramp-down use their own fixed stair interval
    wire [TICK_W-1:0] tick_last = (state == ST_RUN) ? RUN_LAST : SOFT_LAST;
    wire tick_hit = (tick_r >= tick_last);
    wire vrs_lvl_s ref_nxt = tick_hit ?
        '{core: step_toward(ref_r.core, tgt_r.core),
          nb: step_toward(ref_r.nb, tgt_r.nb)} : ref_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= 2'h0;
            hold_r <= 7'h00;
            tgt_r <= '0;
            ref_r <= '0;
            tick_r <= '0;
            pg_r <= 1'b0;
            ps_req_r <= 1'b0;
            defer_r <= 1'b0;
            defer_cmd_r <= '0;
        end else begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            tgt_r <= tgt_nxt;
            ref_r <= ref_nxt;
            tick_r <= tick_hit ? '0 : tick_r + 1'b1;
            pg_r <= pg_nxt;
            ps_req_r <= ps_req_nxt;
            defer_r <= defer_nxt;
            defer_cmd_r <= defer_cmd_nxt;
        end
    end

    // --------------------------------------------------------------------
    // phase shedding
    // --------------------------------------------------------------------
    // only the multi-phase core plane sheds; the northbridge never does
    wire save_want = ps_req_r & ~defer_r & (state == ST_RUN)
                     & (ref_r.core == tgt_r.core);
    wire [3:1] shed_oh = active_r[3] ? 3'b100 :
                         active_r[2] ? 3'b010 : {2'b00, active_r[1]};
    wire [3:1] wake_pool = CFG_MASK & ~active_r;
    wire [3:1] wake_oh = wake_pool[1] ? 3'b001 :
                         wake_pool[2] ? 3'b010 : {wake_pool[3], 2'b00};
    wire [3:1] active_nxt = save_want
        ? active_r & ~(shed_oh & pwm_rise[3:1])
        : active_r | (wake_oh & pwm_rise[3:1]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= CFG_MASK;
        end else begin
            active_r <= active_nxt;
        end
    end

    assign ref_level = ref_r;
    assign plane_power_good = pg_r;
    assign phase_tristate = {~active_r, 1'b0};
    assign power_save_active = (active_r == 3'b000);
    assign fixed_voltage_mode = fixed_s;

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    logic [TICK_W-1:0] gap_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= '0;
        end else if (ref_r != ref_nxt || state_nxt != state) begin
            gap_r <= '0;
        end else if (gap_r != '1) begin
            gap_r <= gap_r + 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_por_gate;
        (state == ST_IDLE) && !por_s |=> (state == ST_IDLE);
    endproperty
    a_por_gate: assert property (p_por_gate) else $error("no por");

    property p_boot_code;
        (state == ST_IDLE) && (state_nxt == ST_SOFT) && !fixed_s
        |=> hold_r == BOOT_VID[$past(strap_sel)];
    endproperty
    a_boot_code: assert property (p_boot_code) else $error("bad boot");

    property p_fix_code;
        (state == ST_SOFT) && fixed_s && en_s
        |=> hold_r == FIX_VID[$past(strap_sel)];
    endproperty
    a_fix_code: assert property (p_fix_code) else $error("bad fixed");

    property p_single_step;
        ref_r.core != $past(ref_r.core)
        |-> (ref_r.core == $past(ref_r.core) + 7'h01) ||
            (ref_r.core == $past(ref_r.core) - 7'h01);
    endproperty
    a_single_step: assert property (p_single_step) else $error("jump");

    property p_slew_gap;
        (state == ST_RUN) && (ref_r != ref_nxt) && (state_nxt == ST_RUN)
        && ($past(state) == ST_RUN) |-> gap_r >= RUN_LAST - 12'h001;
    endproperty
    a_slew_gap: assert property (p_slew_gap) else $error("fast slew");

    property p_pg_rise;
        $rose(plane_power_good) |-> $past(at_target) && $past(regulation_ok);
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("early good");

    property p_en_fall;
        $fell(en_s) |=> !plane_power_good ##1 (tgt_r == '0);
    endproperty
    a_en_fall: assert property (p_en_fall) else $error("no shutdown");

    property p_pok_fall;
        (state == ST_RUN) && pok_fall && en_s && regulation_ok
        |=> tgt_r == hold_pair;
    endproperty
    a_pok_fall: assert property (p_pok_fall) else $error("no boot");

    property p_no_cmd;
        cmd_new && !pok_s && !fixed_s && !defer_r && (state == ST_RUN)
        && !pok_fall |=> tgt_r == $past(tgt_r) || state == ST_DOWN;
    endproperty
    a_no_cmd: assert property (p_no_cmd) else $error("early cmd");

    property p_shed_order;
        $past(save_want) && active_r != $past(active_r)
        |-> ($past(active_r) & ~active_r) == $past(shed_oh);
    endproperty
    a_shed_order: assert property (p_shed_order) else $error("order");

    property p_phase_edge;
        ((active_r ^ $past(active_r)) & ~$past(pwm_rise[3:1])) == 3'b000;
    endproperty
    a_phase_edge: assert property (p_phase_edge) else $error("edge");

    c_soft_done: cover property ($rose(plane_power_good));
    c_cmd_take: cover property (cmd_take ##1 !at_target);
    c_save: cover property ($rose(power_save_active));
    c_defer: cover property ($rose(defer_r) ##[1:1000] $fell(defer_r));

endmodule : vrs_sequencer

//--- vrs_sequencer_tb_top.sv
// Purpose: self-checking bench of the vid reference sequencer
// Assumes: short slew and soft-start counts keep the run brief
// Notes: inputs move on rising edges, outputs are read on falling edges

`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end end

module vrs_sequencer_tb_top;
    import vrs_pkg::*;

    localparam int SLEW = 4;
    localparam int SOFT = 2;
    localparam int BOOT_MV[4] = '{1100, 1000, 900, 800};
    localparam int FIX_MV[4] = '{1400, 1200, 1000, 800};

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic por_ok = 1'b0;
    logic enable = 1'b0;
    logic fixed_sel = 1'b0;
    logic host_power_ok = 1'b0;
    logic strap_clk = 1'b0;
    logic strap_data = 1'b0;
    logic core_ok = 1'b1;
    logic nb_ok = 1'b1;
    logic [3:0] pwm_rise = 4'h0;
    logic link_clk, frame_active, sdata, pg, psa, fixed_mode;
    logic [3:0] phase_tristate;
    vrs_lvl_s ref_level, prev_lvl;
    int err_total = 0;
    int checks_done = 0;

    always #12.5 mclk = ~mclk;

    vrs_svi_master master (.link_clk(link_clk), .frame_active(frame_active),
        .serial_vid_data_line(sdata), .strap_data(strap_data));

    vrs_sequencer #(.NUM_PHASES(4), .SLEW_STEP_CYC(SLEW),
        .SOFT_STEP_CYC(SOFT)) DUT (.mclk(mclk), .rst_n(rst_n),
        .por_ok(por_ok), .enable(enable), .fixed_voltage_select(fixed_sel),
        .host_power_ok(host_power_ok), .strap_clock_level(strap_clk),
        .serial_vid_data_line(sdata), .link_clk(link_clk),
        .frame_active(frame_active), .core_in_reg(core_ok),
        .nb_in_reg(nb_ok), .pwm_rise(pwm_rise), .ref_level(ref_level),
        .plane_power_good(pg), .phase_tristate(phase_tristate),
        .power_save_active(psa), .fixed_voltage_mode(fixed_mode));

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic near(input logic [6:0] a, input logic [6:0] b);
        return (a === b) || (a + 7'h01 === b) || (b + 7'h01 === a);
    endfunction : near

    function automatic vrs_lvl_s lv(input int c, input int n);
        return '{c[6:0], n[6:0]};
    endfunction : lv

    // every move of either reference is one stair step
    always @(negedge mclk) begin
        if (rst_n && ref_level !== prev_lvl) begin
            `CHK(near(prev_lvl.core, ref_level.core), 1'b1)
            `CHK(near(prev_lvl.nb, ref_level.nb), 1'b1)
        end
        prev_lvl <= ref_level;
    end

    task automatic report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wait_lvl(input vrs_lvl_s exp, output int n);
        n = 0;
        while (ref_level !== exp) begin
            @(negedge mclk);
            n++;
            if (n > 3000) begin
                `CHK(ref_level, exp)
                report_and_stop();
            end
        end
    endtask : wait_lvl

    task automatic wait_pg(input logic v);
        int n;
        n = 0;
        while (pg !== v) begin
            @(negedge mclk);
            n++;
            if (n > 3000) begin
                `CHK(pg, v)
                report_and_stop();
            end
        end
    endtask : wait_pg

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic pulse(input int k, input logic [3:0] exp);
        @(posedge mclk) pwm_rise <= 4'h1 << k;
        @(posedge mclk) pwm_rise <= 4'h0;
        @(negedge mclk);
        `CHK(phase_tristate, exp)
    endtask : pulse

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic start_run(input logic fx, input logic [1:0] idx);
        int mv;
        // one level is 12.5 mV
        mv = (fx ? FIX_MV[idx] : BOOT_MV[idx]) * 2 / 25;
        @(posedge mclk);
        fixed_sel <= fx;
        {strap_clk, strap_data} <= idx;
        tick(4);
        enable <= 1'b1;
        wait_pg(1'b1);
        `CHK(ref_level, lv(mv, mv))
        `CHK(fixed_mode, fx)
    endtask : start_run

    task automatic stop_run;
        int n;
        @(posedge mclk) enable <= 1'b0;
        wait_pg(1'b0);
        wait_lvl(lv(0, 0), n);
    endtask : stop_run

    // enable raised before power-on reset is satisfied must not start
    task automatic t_por;
        @(posedge mclk) enable <= 1'b1;
        tick(40);
        @(negedge mclk);
        `CHK(ref_level, lv(0, 0))
        `CHK(pg, 1'b0)
        @(posedge mclk) enable <= 1'b0;
        por_ok <= 1'b1;
        tick(4);
    endtask : t_por

    task automatic t_straps;
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 4; i++) begin
                start_run(f[0], i[1:0]);
                stop_run();
            end
        end
    endtask : t_straps

    // jumpers moved mid soft-start: the fixed target follows them
    task automatic t_fixed_follow;
        @(posedge mclk) {fixed_sel, strap_clk, strap_data} <= 3'h4;
        tick(4);
        enable <= 1'b1;
        tick(20);
        {strap_clk, strap_data} <= 2'h3;
        wait_pg(1'b1);
        `CHK(ref_level, lv(64, 64))
        stop_run();
    endtask : t_fixed_follow

    task automatic t_svi;
        int n;
        start_run(1'b0, 2'h0);
        master.send('{1'b1, 1'b1, 1'b1, 7'h20});
        tick(40);
        @(negedge mclk);
        `CHK(ref_level, lv(88, 88))
        @(posedge mclk) host_power_ok <= 1'b1;
        tick(4);
        master.send('{1'b1, 1'b1, 1'b1, 7'h20});
        wait_lvl(lv(92, 92), n);
        `CHK(n >= 3 * SLEW, 1'b1)
        master.send('{1'b1, 1'b0, 1'b1, 7'h7c});
        wait_lvl(lv(0, 92), n);
        // the core plane is off, so its lost regulation must not count
        @(posedge mclk) core_ok <= 1'b0;
        tick(8);
        @(negedge mclk);
        `CHK(pg, 1'b1)
        @(posedge mclk) {strap_clk, strap_data} <= 2'h3;
        host_power_ok <= 1'b0;
        core_ok <= 1'b1;
        wait_lvl(lv(88, 88), n);
        @(posedge mclk) host_power_ok <= 1'b1;
        tick(60);
        @(negedge mclk);
        `CHK(ref_level, lv(88, 88))
    endtask : t_svi

    task automatic t_psave;
        int n;
        master.send('{1'b1, 1'b1, 1'b0, 7'h24});
        tick(12);
        pulse(1, 4'h0);
        pulse(3, 4'h8);
        pulse(2, 4'hc);
        pulse(1, 4'he);
        `CHK(psa, 1'b1)
        `CHK(ref_level, lv(88, 88))
        // a level change in save waits until every phase is back
        master.send('{1'b1, 1'b1, 1'b0, 7'h20});
        tick(12);
        @(negedge mclk);
        `CHK(ref_level, lv(88, 88))
        pulse(3, 4'he);
        pulse(1, 4'hc);
        pulse(2, 4'h8);
        pulse(3, 4'h0);
        wait_lvl(lv(92, 92), n);
        pulse(3, 4'h8);
        pulse(2, 4'hc);
        pulse(1, 4'he);
        `CHK(psa, 1'b1)
        master.send('{1'b1, 1'b1, 1'b1, 7'h24});
        tick(12);
        pulse(3, 4'he);
        pulse(1, 4'hc);
        pulse(2, 4'h8);
        pulse(3, 4'h0);
        `CHK(psa, 1'b0)
    endtask : t_psave

    // regulation lost in run: power good drops, both planes go to zero
    task automatic t_lost;
        int n;
        @(posedge mclk) nb_ok <= 1'b0;
        wait_pg(1'b0);
        wait_lvl(lv(0, 0), n);
    endtask : t_lost

    initial begin
        tick(5);
        rst_n <= 1'b1;
        t_por();
        t_straps();
        t_fixed_follow();
        t_svi();
        t_psave();
        t_lost();
        report_and_stop();
    end
endmodule : vrs_sequencer_tb_top

//--- vrs_svi_master.sv
// Purpose: serial vid bus master model sending framed set-vid commands
// Assumes: link clock idles low and toggles only inside a frame
// Notes: outside frames the data pin shows the strap jumper level

`timescale 1ns/1ps

module vrs_svi_master (
    // link pins
    output logic link_clk,
    output logic frame_active,
    output logic serial_vid_data_line,
    // strap level seen on the data pin outside frames
    input wire logic strap_data
);
    import vrs_pkg::*;

    logic frame_bit = 1'b0;

    initial begin
        link_clk = 1'b0;
        frame_active = 1'b0;
    end

    // the jumper sets the idle level, so no stale frame bit lingers
    assign serial_vid_data_line = frame_active ? frame_bit : strap_data;

    // -------------------------------------------------------------------
    // one frame, msb first, ps_keep at bit 7 (0 asks for power save)
    // -------------------------------------------------------------------
    task automatic send(input vrs_cmd_s c);
        logic [9:0] bits;
        bits = c;
        #11;
        frame_active = 1'b1;
        for (int i = 9; i >= 0; i--) begin
            frame_bit = bits[i];
            #32 link_clk = 1'b1;
            #32 link_clk = 1'b0;
        end
        frame_active = 1'b0;
    endtask : send
endmodule : vrs_svi_master
